/* logic/csp_status_word_builder.sv */
// status word builder for cyclic synchronous position mode
// Summary of operation
// - bit 15 set while torque limit reached
// - bit 13 set when deviation exceeds window
// - bit 13 cleared only by alarm 10h/30h clear or by reset
// - bit 12 zero, target ignored when blocked
// - bit 12 one, target accepted otherwise
// - bit 11 set while any internal limit
// - bit 9 set once initialization finishes
// - bit 7 follows warning causes, self clearing
// - voltage bit set while main power present
// - halt bit forces immediate stop
`timescale 1ns/1ps
`default_nettype none
module csp_status_word_builder
  import csp_status_pkg::*;
(
  input  wire logic                    CLK,
  input  wire logic                    ARST_N,
  input  wire logic                    TORQUE_LIMIT_REACHED,
  input  wire logic                    DEVIATION_OVER_WINDOW,
  input  wire logic                    ALARM_CLEAR,
  input  wire logic [7:0]              ALARM_CODE,
  input  wire logic                    OP_ENABLED,
  input  wire logic                    MOTOR_EXCITED,
  input  wire logic                    HALT_BIT,
  input  wire logic                    STOP_INPUT,
  input  wire logic                    FORWARD_LIMIT_SENSOR,
  input  wire logic                    REVERSE_LIMIT_SENSOR,
  input  wire logic                    FORWARD_MOTION_BLOCK,
  input  wire logic                    REVERSE_MOTION_BLOCK,
  input  wire logic                    SOFT_LIMIT,
  input  wire logic                    MECH_LIMIT,
  input  wire logic                    INIT_DONE,
  input  wire logic                    INFO_PRESENT,
  input  wire logic                    MAIN_POWER,
  input  wire logic [STATE_BITS_W-1:0] STATE_BITS,
  input  wire logic                    TARGET_VALID,
  input  wire logic [31:0]             TARGET_POS,
  output var  logic [STATUS_W-1:0]     DRIVE_STATUS_WORD,
  output var  logic [31:0]             ACCEPTED_POS,
  output var  logic                    ACCEPTED_STB,
  output var  logic                    IMMEDIATE_STOP
);
  localparam int unsigned NPIN = 11;

  logic            rst_meta_q;
  logic            rst_n;
  logic [NPIN-1:0] pins_async;
  logic [NPIN-1:0] pins;

  // reset released through two flops, asserted at once
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // pin-level inputs arrive from outside the clock domain
  assign pins_async = {TORQUE_LIMIT_REACHED, STOP_INPUT,
                       FORWARD_LIMIT_SENSOR, REVERSE_LIMIT_SENSOR,
                       FORWARD_MOTION_BLOCK, REVERSE_MOTION_BLOCK,
                       MECH_LIMIT, MAIN_POWER, INFO_PRESENT,
                       MOTOR_EXCITED, DEVIATION_OVER_WINDOW};

  pin_sync #(.W(NPIN)) u_sync (
    .clk      (CLK),
    .rst_n    (rst_n),
    .async_in (pins_async),
    .sync_out (pins)
  );

  logic torque_s, stop_s, fls_s, rls_s, fblk_s, rblk_s;
  logic mech_s, power_s, info_s, excited_s, dev_s;
  assign {torque_s, stop_s, fls_s, rls_s, fblk_s, rblk_s,
          mech_s, power_s, info_s, excited_s, dev_s} = pins;

  follow_state_e fe_q;
  follow_state_e fe_d;
  logic          int_limit;
  logic          blocked;
  logic          alarm_match;
  logic [STATUS_W-1:0] status_d;
  logic [31:0]   acc_pos_d;
  logic          acc_stb_d;
  logic          stop_d;
  logic          remote_q;
  logic          remote_d;

  // only these two alarms own the following-error flag
  function automatic logic is_follow_alarm(input logic [7:0] code);
    is_follow_alarm = (code == ALARM_DEVIATION)
                    || (code == ALARM_OVERLOAD);
  endfunction

  always_comb
  begin
    int_limit   = fls_s | rls_s | fblk_s | rblk_s
                | SOFT_LIMIT | mech_s;
    blocked     = !OP_ENABLED | !excited_s | HALT_BIT
                | stop_s | int_limit;
    alarm_match = ALARM_CLEAR && is_follow_alarm(ALARM_CODE);
    fe_d = fe_q;
    case (fe_q)
      FE_CLEAR:
        if (dev_s)
          fe_d = FE_SET;
      FE_SET:
        // set wins: a deviation still present keeps the flag up
        if (alarm_match && !dev_s)
          fe_d = FE_CLEAR;
      default:
        fe_d = FE_CLEAR;
    endcase
    remote_d = remote_q | INIT_DONE;
    status_d                 = STATUS_RESET;
    status_d[BIT_TORQUE_LIM] = torque_s;
    status_d[BIT_FOLLOW_ERR] = (fe_d == FE_SET);
    status_d[BIT_TARGET_OK]  = !blocked;
    status_d[BIT_INT_LIMIT]  = int_limit;
    status_d[BIT_REMOTE]     = remote_d;
    status_d[BIT_WARNING]    = info_s;
    status_d[STATE_BITS_W-1:0] = STATE_BITS;
    status_d[BIT_VOLT_EN]    = power_s;
    acc_stb_d = TARGET_VALID && !blocked;
    acc_pos_d = acc_stb_d ? TARGET_POS : ACCEPTED_POS;
    stop_d    = HALT_BIT;
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fe_q              <= FE_CLEAR;
      remote_q          <= 1'b0;
      DRIVE_STATUS_WORD <= STATUS_RESET;
      ACCEPTED_POS      <= '0;
      ACCEPTED_STB      <= 1'b0;
      IMMEDIATE_STOP    <= 1'b0;
    end
    else
    begin
      fe_q              <= fe_d;
      remote_q          <= remote_d;
      DRIVE_STATUS_WORD <= status_d;
      ACCEPTED_POS      <= acc_pos_d;
      ACCEPTED_STB      <= acc_stb_d;
      IMMEDIATE_STOP    <= stop_d;
    end
  end

  // checks sleep until the internal reset copy is released
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  chk_halt_stop: assert property (
    HALT_BIT |=> IMMEDIATE_STOP)
    else $error("halt did not raise immediate stop");
  chk_halt_no_accept: assert property (
    HALT_BIT |=> !ACCEPTED_STB && !DRIVE_STATUS_WORD[BIT_TARGET_OK])
    else $error("target accepted while halted");
  chk_accept_pos: assert property (
    ACCEPTED_STB |-> DRIVE_STATUS_WORD[BIT_TARGET_OK]
                     && ACCEPTED_POS == $past(TARGET_POS))
    else $error("accepted position mismatch");
  chk_follow_hold: assert property (
    DRIVE_STATUS_WORD[BIT_FOLLOW_ERR] && !$past(alarm_match)
      |-> $past(DRIVE_STATUS_WORD[BIT_FOLLOW_ERR]) || $past(dev_s))
    else $error("following error changed without cause");
  chk_follow_keep: assert property (
    $past(DRIVE_STATUS_WORD[BIT_FOLLOW_ERR]) && !$past(alarm_match)
      |-> DRIVE_STATUS_WORD[BIT_FOLLOW_ERR])
    else $error("following error cleared without alarm clear");
  chk_follow_set: assert property (
    dev_s |=> DRIVE_STATUS_WORD[BIT_FOLLOW_ERR])
    else $error("deviation not flagged");
  chk_limit_bit: assert property (
    int_limit |=> DRIVE_STATUS_WORD[BIT_INT_LIMIT]
                  && !DRIVE_STATUS_WORD[BIT_TARGET_OK])
    else $error("internal limit not reported");
  chk_remote_sticky: assert property (
    DRIVE_STATUS_WORD[BIT_REMOTE] |=> DRIVE_STATUS_WORD[BIT_REMOTE])
    else $error("remote bit dropped");
  chk_spare_zero: assert property (
    !DRIVE_STATUS_WORD[BIT_SPARE_14] && !DRIVE_STATUS_WORD[BIT_SPARE_10]
    && !DRIVE_STATUS_WORD[BIT_SPARE_8])
    else $error("unused status bit set");
  chk_torque_warn: assert property (
    DRIVE_STATUS_WORD[BIT_TORQUE_LIM] == $past(torque_s)
    && DRIVE_STATUS_WORD[BIT_WARNING] == $past(info_s)
    && DRIVE_STATUS_WORD[BIT_VOLT_EN] == $past(power_s))
    else $error("torque, warning or voltage bit wrong");
  chk_target_take: assert property (
    TARGET_VALID && !blocked |=> ACCEPTED_STB
                                 && ACCEPTED_POS == $past(TARGET_POS))
    else $error("free target not accepted");
  chk_target_drop: assert property (
    TARGET_VALID && blocked |=> !ACCEPTED_STB && $stable(ACCEPTED_POS))
    else $error("blocked target taken");
  chk_follow_clear: assert property (
    alarm_match && !dev_s |=> !DRIVE_STATUS_WORD[BIT_FOLLOW_ERR])
    else $error("following error not cleared by alarm clear");
  chk_limit_clear: assert property (
    !int_limit |=> !DRIVE_STATUS_WORD[BIT_INT_LIMIT])
    else $error("internal limit bit stuck");

  cov_accept: cover property (ACCEPTED_STB);
  cov_follow_clear: cover property (
    DRIVE_STATUS_WORD[BIT_FOLLOW_ERR] ##1 !DRIVE_STATUS_WORD[BIT_FOLLOW_ERR]);
  cov_limit: cover property (DRIVE_STATUS_WORD[BIT_INT_LIMIT]);
  cov_remote: cover property (DRIVE_STATUS_WORD[BIT_REMOTE]);
  cov_follow_set_wins: cover property (
    alarm_match && dev_s ##1 DRIVE_STATUS_WORD[BIT_FOLLOW_ERR]);
endmodule // csp_status_word_builder
`default_nettype wire

/* logic/pin_sync.sv */
// two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= meta_d;
      sync_out <= sync_d;
    end
  end
endmodule // pin_sync
`default_nettype wire

/* pkg/csp_status_pkg.sv */
// constants for the cyclic position status word builder
`default_nettype none
package csp_status_pkg;
  localparam int unsigned STATUS_W        = 16;
  localparam int unsigned BIT_TORQUE_LIM  = 15;
  localparam int unsigned BIT_SPARE_14    = 14;
  localparam int unsigned BIT_FOLLOW_ERR  = 13;
  localparam int unsigned BIT_TARGET_OK   = 12;
  localparam int unsigned BIT_INT_LIMIT   = 11;
  localparam int unsigned BIT_SPARE_10    = 10;
  localparam int unsigned BIT_REMOTE      = 9;
  localparam int unsigned BIT_SPARE_8     = 8;
  localparam int unsigned BIT_WARNING     = 7;
  localparam int unsigned BIT_VOLT_EN     = 4;
  localparam int unsigned STATE_BITS_W    = 7;
  localparam logic [7:0]  ALARM_DEVIATION = 8'h10;
  localparam logic [7:0]  ALARM_OVERLOAD  = 8'h30;
  localparam logic [15:0] STATUS_RESET    = 16'h0000;
  typedef enum logic [1:0] {
    FE_CLEAR = 2'b01,
    FE_SET   = 2'b10
  } follow_state_e;
endpackage
`default_nettype wire

/* tb/fieldbus_master.sv */
// fieldbus master model sending cyclic target positions
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master (
  input  wire logic        CLK,
  input  wire logic        ACCEPTED_STB,
  output var  logic        TARGET_VALID,
  output var  logic [31:0] TARGET_POS
);
  initial TARGET_VALID = 1'b0;
  initial TARGET_POS = 32'h0000_0000;
  // one target per cycle back to back; strobes counted as they return
  task automatic send(input logic [31:0] p, input int n, output int acc);
    acc = 0;
    for (int i = 0; i < n; i++)
    begin
      TARGET_VALID = 1'b1;
      TARGET_POS = p + i;
      @(negedge CLK);
      acc += (ACCEPTED_STB === 1'b1);
    end
    TARGET_VALID = 1'b0;
    // released bus shows no stale value
    TARGET_POS = ~TARGET_POS;
  endtask
endmodule // fieldbus_master
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the cyclic position status word builder
`timescale 1ns/1ps
`default_nettype none
module testbench import csp_status_pkg::*;;
  logic CLK = 0, ARST_N = 0, tq = 0, dev = 0, aclr = 0, init = 0;
  logic info = 0, pwr = 0;
  logic [7:0]  acode = 8'h00;
  logic [9:0]  blk = 10'h000;
  logic [6:0]  st = 7'h00;
  logic        tv, astb, istop;
  logic [31:0] tp, apos;
  logic [15:0] sw;
  int          n_errors = 0, checks = 0, got;

  csp_status_word_builder u_dut (.CLK(CLK), .ARST_N(ARST_N),
    .TORQUE_LIMIT_REACHED(tq), .DEVIATION_OVER_WINDOW(dev),
    .ALARM_CLEAR(aclr), .ALARM_CODE(acode), .OP_ENABLED(~blk[0]),
    .MOTOR_EXCITED(~blk[1]), .HALT_BIT(blk[2]), .STOP_INPUT(blk[3]),
    .FORWARD_LIMIT_SENSOR(blk[4]), .REVERSE_LIMIT_SENSOR(blk[5]),
    .FORWARD_MOTION_BLOCK(blk[6]), .REVERSE_MOTION_BLOCK(blk[7]),
    .SOFT_LIMIT(blk[8]), .MECH_LIMIT(blk[9]), .INIT_DONE(init),
    .INFO_PRESENT(info), .MAIN_POWER(pwr), .STATE_BITS(st),
    .TARGET_VALID(tv), .TARGET_POS(tp), .DRIVE_STATUS_WORD(sw),
    .ACCEPTED_POS(apos), .ACCEPTED_STB(astb), .IMMEDIATE_STOP(istop));
  fieldbus_master u_master (.CLK(CLK), .ACCEPTED_STB(astb),
    .TARGET_VALID(tv), .TARGET_POS(tp));

  initial
  begin
    forever #5 CLK = ~CLK;
  end

  task chk(input logic g, input logic e);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %0t status bit %b expected %b", $time, g, e);
    end
  endtask
  task chk_word(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %0t value %h expected %h", $time, g, e);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task clr(input logic [7:0] c);
    acode = c;
    aclr = 1;
    step(1);
    aclr = 0;
    step(2);
  endtask
  task test_done;
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    step(6);
    ARST_N = 1;
    step(5);
    chk(sw[BIT_REMOTE], 0);
    chk(sw[BIT_SPARE_14] | sw[BIT_SPARE_10] | sw[BIT_SPARE_8], 0);
    {init, pwr, tq, info} = 4'hF;
    step(4);
    chk(sw[BIT_REMOTE], 1);
    chk(sw[BIT_VOLT_EN], 1);
    chk(sw[BIT_TORQUE_LIM], 1);
    chk(sw[BIT_WARNING], 1);
    chk_word(sw[STATE_BITS_W-1:0], 32'h0000_0010);
    {init, pwr, tq, info} = 4'h0;
    st = 7'h37;
    step(4);
    chk(sw[BIT_REMOTE], 1);
    chk(sw[BIT_VOLT_EN], 0);
    chk_word(sw[STATE_BITS_W-1:0], 32'h0000_0027);
    chk(sw[BIT_TORQUE_LIM], 0);
    chk(sw[BIT_WARNING], 0);
    chk(sw[BIT_TARGET_OK], 1);
    u_master.send(32'h1234_5678, 3, got);
    chk_word(got, 3);
    chk_word(apos, 32'h1234_567A);
    // each blocking cause alone: limits are sources 4 to 9
    for (int i = 0; i < 10; i++)
    begin
      blk = 10'h001 << i;
      step(4);
      chk(sw[BIT_TARGET_OK], 0);
      chk(sw[BIT_INT_LIMIT], i >= 4);
      chk(istop, i == 2);
      u_master.send(32'h0000_00FF, 2, got);
      chk_word(got, 0);
      chk_word(apos, 32'h1234_567A);
    end
    blk = 10'h000;
    dev = 1;
    step(4);
    chk(sw[BIT_FOLLOW_ERR], 1);
    dev = 0;
    step(4);
    chk(sw[BIT_FOLLOW_ERR], 1);
    clr(8'h20);
    chk(sw[BIT_FOLLOW_ERR], 1);
    clr(ALARM_DEVIATION);
    chk(sw[BIT_FOLLOW_ERR], 0);
    dev = 1;
    step(4);
    // deviation still present at the clear: the set wins
    clr(ALARM_OVERLOAD);
    chk(sw[BIT_FOLLOW_ERR], 1);
    dev = 0;
    step(4);
    chk(sw[BIT_FOLLOW_ERR], 1);
    clr(ALARM_OVERLOAD);
    chk(sw[BIT_FOLLOW_ERR], 0);
    // mid-run reset drops remote and the following-error flag
    dev = 1;
    step(4);
    ARST_N = 0;
    dev = 0;
    step(2);
    chk_word(sw, 32'h0000_0000);
    ARST_N = 1;
    step(5);
    chk(sw[BIT_REMOTE], 0);
    chk(sw[BIT_FOLLOW_ERR], 0);
    test_done;
  end

  // tests need about 120 cycles; allow over sixteen times that
  initial
  begin
    #20000;
    n_errors++;
    test_done;
  end
endmodule // testbench
`default_nettype wire
